// [gpio_board_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Board pulls each undriven pad to ext_val; the port's own driver wins
module gpio_board_model (
   input wire gpio_port_pkg::pad_drive_t pad_drive,
   input wire logic [7:0] ext_val,
   output logic [7:0] pad_in
);
   // Pins 4 and 5 double as transceiver receive lines from ext_val
   assign pad_in = (pad_drive.oe & pad_drive.out) |
      (~pad_drive.oe & ext_val);
endmodule

`default_nettype wire

// [gpio_pin_cell.sv]
`timescale 1ns/1ps
`default_nettype none

module gpio_pin_cell (
   input wire logic dir,
   input wire logic latch,
   input wire logic force_out,
   input wire logic force_in,
   input wire logic alt_sel,
   input wire logic alt_data,
   input wire logic digital_en,
   input wire logic pad_in,
   output logic pad_oe,
   output logic pad_out,
   output logic pin_level
);

   // A forced output wins over a forced input
   assign pad_oe = force_out | (~force_in & ~dir);
   assign pad_out = alt_sel ? alt_data : latch;
   // Disabled digital input reads low
   assign pin_level = digital_en & pad_in;

endmodule

`default_nettype wire

// [gpio_port.sv]
// How it works
// RQ1: Eight pins, each individually input or output unless input-only.
// RQ2: Direction bit 1 turns the pin driver off; pin is input.
// RQ3: Direction bit 0 drives the pin from its output latch bit.
// RQ4: Output latch reads return stored latch values, never pin levels.
// RQ5: Enabled peripherals may force a pin to output or input.
// RQ6: Direction register reads return stored bits despite overrides.
// RQ7: Pins 4 and 5 have no direction bits; digital use is input only.
// RQ8: External transceiver mode keeps pins 4 and 5 as inputs.
// RQ9: On-chip transceiver mode lets USB engine set pins 4, 5 direction.
// RQ10: After reset all pins except 2, 4, 5 are digital inputs.
// RQ11: Pin 2 starts analog; digital input needs its analog-select bit set.
// RQ12: Software clears USB enable and sets transceiver disable first.
// RQ13: On-chip transceiver resets enabled; pins 4, 5 not digital yet.
// RQ14: Timer oscillator enabled takes pins 0, 1; digital I/O disabled.
// RQ15: Pin 0 as input feeds the timer external clock.
// RQ16: External transceiver mode drives its active-low enable on pin 1.
// RQ17: On-chip transceiver mode uses pins 4, 5 as bus data lines.
// RQ18: External transceiver receive data come in on pins 4 and 5.
// RQ19: Pins 0, 1, 2 carry remappable peripheral signals per direction.
// RQ20: Pin 2 as output can carry the pulse generator signal.
// RQ21: Pin level writes update latch; reads return sampled pin levels.
//
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module gpio_port #(
   parameter int PORT_W = gpio_port_pkg::PORT_W
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire gpio_port_pkg::apb_req_t apb_req,
   output gpio_port_pkg::apb_rsp_t apb_rsp,
   input wire gpio_port_pkg::periph_req_t periph_req,
   input wire gpio_port_pkg::usb_req_t usb_req,
   input wire logic [PORT_W-1:0] pad_in,
   output gpio_port_pkg::pad_drive_t pad_drive,
   output logic usb_minus_in,
   output logic usb_plus_in,
   output logic xcvr_minus_rx,
   output logic xcvr_plus_rx,
   output logic timer_ext_clock_in,
   output logic timer_osc_active,
   output logic [PORT_W-1:0] pin_level
);

   typedef struct packed {
      logic [7:0] dir;
      logic [7:0] lat;
      logic [7:0] usb_ctrl;
      logic [7:0] usb_cfg;
      logic [7:0] analog_cfg;
      logic [7:0] periph_ctrl;
      logic [7:0] pins;
      logic [7:0] raw;
      logic [7:0] pad_out;
      logic [7:0] pad_oe;
      logic [31:0] prdata;
      logic slverr;
   } state_t;

   state_t state_q;
   state_t state_d;

   logic usb_en;
   logic xcvr_dis;
   logic usb_onchip;
   logic usb_ext;
   logic osc_en;
   logic pulse_en;
   logic setup_ph;
   logic access_wr;
   logic [7:0] eff_dir;
   logic [7:0] force_out;
   logic [7:0] force_in;
   logic [7:0] alt_sel;
   logic [7:0] alt_data;
   logic [7:0] dig_en;
   logic [7:0] cell_oe;
   logic [7:0] cell_out;
   logic [7:0] cell_level;
   logic [7:0] wbyte;
   logic [7:0] rbyte;
   logic hit;

   assign usb_en = state_q.usb_ctrl[gpio_port_pkg::USB_EN_BIT];
   assign xcvr_dis = state_q.usb_cfg[gpio_port_pkg::XCVR_DIS_BIT];
   assign usb_onchip = usb_en & ~xcvr_dis;
   assign usb_ext = usb_en & xcvr_dis;
   assign osc_en = state_q.periph_ctrl[gpio_port_pkg::TMR_OSC_EN_BIT];
   assign pulse_en = state_q.periph_ctrl[gpio_port_pkg::PULSE_EN_BIT];

   assign setup_ph = apb_req.psel & ~apb_req.penable;
   assign access_wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign wbyte = apb_req.pwdata[7:0];

   // Pin mux inputs, one bit per pin
   always_comb begin
      // Pins 4 and 5 behave as if their direction bit were always 1
      eff_dir = state_q.dir | ~gpio_port_pkg::DIR_IMPL_MASK; // RQ7
      force_out = periph_req.force_out; // RQ5
      force_in = periph_req.force_in; // RQ5
      alt_sel = periph_req.sel; // RQ19
      alt_data = periph_req.data; // RQ19
      dig_en = 8'hFF;
      // Oscillator pads are analog; the digital path must stay off
      if (osc_en) begin
         force_in[gpio_port_pkg::PIN_OSC_OUT] = 1'b1; // RQ14
         force_in[gpio_port_pkg::PIN_OSC_IN] = 1'b1; // RQ14
         force_out[gpio_port_pkg::PIN_OSC_OUT] = 1'b0; // RQ14
         force_out[gpio_port_pkg::PIN_OSC_IN] = 1'b0; // RQ14
         dig_en[gpio_port_pkg::PIN_OSC_OUT] = 1'b0; // RQ14
         dig_en[gpio_port_pkg::PIN_OSC_IN] = 1'b0; // RQ14
      end
      if (usb_ext) begin
         // Enable goes out only while the direction bit is 0 or a peripheral forces pin 1 to output
         alt_sel[gpio_port_pkg::PIN_OSC_IN] = 1'b1; // RQ16
         alt_data[gpio_port_pkg::PIN_OSC_IN] = usb_req.xcvr_oe_n; // RQ16
      end
      if (pulse_en) begin
         alt_sel[gpio_port_pkg::PIN_ANALOG] = 1'b1; // RQ20
         alt_data[gpio_port_pkg::PIN_ANALOG] = periph_req.data[2]; // RQ20
      end
      dig_en[gpio_port_pkg::PIN_ANALOG] =
         state_q.analog_cfg[gpio_port_pkg::PIN2_ANALOG_SEL_BIT]; // RQ11
      // Pins 4 and 5 serve USB, else digital input only
      force_out[gpio_port_pkg::PIN_USB_MINUS] =
         usb_onchip & usb_req.drive_en; // RQ9 RQ17
      force_out[gpio_port_pkg::PIN_USB_PLUS] =
         usb_onchip & usb_req.drive_en; // RQ9 RQ17
      force_in[gpio_port_pkg::PIN_USB_MINUS] = ~force_out[4]; // RQ7 RQ8
      force_in[gpio_port_pkg::PIN_USB_PLUS] = ~force_out[5]; // RQ7 RQ8
      alt_sel[gpio_port_pkg::PIN_USB_MINUS] = 1'b1; // RQ17
      alt_sel[gpio_port_pkg::PIN_USB_PLUS] = 1'b1; // RQ17
      alt_data[gpio_port_pkg::PIN_USB_MINUS] = usb_req.minus_out; // RQ17
      alt_data[gpio_port_pkg::PIN_USB_PLUS] = usb_req.plus_out; // RQ17
      // Digital read only once USB and its transceiver are both off
      dig_en[gpio_port_pkg::PIN_USB_MINUS] = ~usb_en & xcvr_dis; // RQ12 RQ13
      dig_en[gpio_port_pkg::PIN_USB_PLUS] = ~usb_en & xcvr_dis; // RQ12 RQ13
   end

   genvar gi;
   generate
      for (gi = 0; gi < PORT_W; gi++) begin : g_pin
         // RQ1
         gpio_pin_cell u_cell (
            .dir(eff_dir[gi]),
            .latch(state_q.lat[gi]),
            .force_out(force_out[gi]),
            .force_in(force_in[gi]),
            .alt_sel(alt_sel[gi]),
            .alt_data(alt_data[gi]),
            .digital_en(dig_en[gi]),
            .pad_in(pad_in[gi]),
            .pad_oe(cell_oe[gi]),
            .pad_out(cell_out[gi]),
            .pin_level(cell_level[gi])
         );
      end
   endgenerate

   // Register read mux
   always_comb begin
      rbyte = 8'h00;
      hit = 1'b1;
      case (apb_req.paddr)
         gpio_port_pkg::OFS_PIN_LEVEL: begin
            rbyte = state_q.pins; // RQ21
         end
         gpio_port_pkg::OFS_DIRECTION: begin
            // Stored bits only, whatever overrides are active
            rbyte = state_q.dir; // RQ6
         end
         gpio_port_pkg::OFS_OUT_LATCH: begin
            rbyte = state_q.lat; // RQ4
         end
         gpio_port_pkg::OFS_USB_CTRL: begin
            rbyte = state_q.usb_ctrl;
         end
         gpio_port_pkg::OFS_USB_CFG: begin
            rbyte = state_q.usb_cfg;
         end
         gpio_port_pkg::OFS_ANALOG_CFG: begin
            rbyte = state_q.analog_cfg;
         end
         gpio_port_pkg::OFS_PERIPH_CTRL: begin
            rbyte = state_q.periph_ctrl;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   always_comb begin
      state_d = state_q;
      state_d.pins = cell_level;
      // Unmasked samples: USB receive needs pins 4, 5 while digital read is off
      state_d.raw = pad_in;
      // Pads are driven from flops, one cycle behind the mux
      state_d.pad_out = cell_out;
      state_d.pad_oe = cell_oe; // RQ2 RQ3
      // Read data and error are captured in the setup cycle
      if (setup_ph) begin
         state_d.prdata = {24'h000000, rbyte};
         state_d.slverr = ~hit;
      end
      if (access_wr) begin
         case (apb_req.paddr)
            gpio_port_pkg::OFS_PIN_LEVEL: begin
               // Writes land in the latch, not on the pins directly
               state_d.lat = wbyte & gpio_port_pkg::LAT_IMPL_MASK; // RQ21
            end
            gpio_port_pkg::OFS_DIRECTION: begin
               state_d.dir = wbyte & gpio_port_pkg::DIR_IMPL_MASK; // RQ7
            end
            gpio_port_pkg::OFS_OUT_LATCH: begin
               state_d.lat = wbyte & gpio_port_pkg::LAT_IMPL_MASK; // RQ4
            end
            gpio_port_pkg::OFS_USB_CTRL: begin
               state_d.usb_ctrl = wbyte;
            end
            gpio_port_pkg::OFS_USB_CFG: begin
               state_d.usb_cfg = wbyte;
            end
            gpio_port_pkg::OFS_ANALOG_CFG: begin
               state_d.analog_cfg = wbyte;
            end
            gpio_port_pkg::OFS_PERIPH_CTRL: begin
               state_d.periph_ctrl = wbyte;
            end
            default: begin
               state_d.slverr = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_q.dir <= gpio_port_pkg::DIR_RST; // RQ10
         state_q.lat <= gpio_port_pkg::LAT_RST;
         state_q.usb_ctrl <= gpio_port_pkg::USB_CTRL_RST;
         // Transceiver comes up enabled
         state_q.usb_cfg <= gpio_port_pkg::USB_CFG_RST; // RQ13
         // Pin 2 comes up analog
         state_q.analog_cfg <= gpio_port_pkg::ANALOG_CFG_RST; // RQ11
         state_q.periph_ctrl <= gpio_port_pkg::PERIPH_CTRL_RST;
         state_q.pins <= 8'h00;
         state_q.raw <= 8'h00;
         state_q.pad_out <= 8'h00;
         state_q.pad_oe <= 8'h00; // RQ10
         state_q.prdata <= 32'h00000000;
         state_q.slverr <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   // Zero wait states: the access phase always completes at once
   assign apb_rsp = '{pready: 1'b1,
      pslverr: state_q.slverr & apb_req.psel & apb_req.penable,
      prdata: state_q.prdata};

   assign pad_drive = '{out: state_q.pad_out, oe: state_q.pad_oe};
   assign pin_level = state_q.pins;

   // Raw pad samples for USB are taken from the flopped pads only
   assign usb_minus_in = usb_onchip &
      state_q.raw[gpio_port_pkg::PIN_USB_MINUS]; // RQ17
   assign usb_plus_in = usb_onchip &
      state_q.raw[gpio_port_pkg::PIN_USB_PLUS]; // RQ17
   assign xcvr_minus_rx = usb_ext &
      state_q.raw[gpio_port_pkg::PIN_USB_MINUS]; // RQ18
   assign xcvr_plus_rx = usb_ext &
      state_q.raw[gpio_port_pkg::PIN_USB_PLUS]; // RQ18
   assign timer_ext_clock_in = state_q.pins[0] &
      state_q.dir[gpio_port_pkg::PIN_OSC_OUT]; // RQ15
   assign timer_osc_active = osc_en; // RQ14

endmodule

`default_nettype wire

// [gpio_port_checker.sv]
`timescale 1ns/1ps
`default_nettype none

module gpio_port_checker #(
   parameter int PORT_W = 8
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire gpio_port_pkg::periph_req_t periph_req,
   input wire gpio_port_pkg::usb_req_t usb_req,
   input wire logic [PORT_W-1:0] pad_in,
   input wire gpio_port_pkg::pad_drive_t pad_drive,
   input wire logic usb_minus_in,
   input wire logic usb_plus_in,
   input wire logic xcvr_minus_rx,
   input wire logic xcvr_plus_rx,
   input wire logic timer_ext_clock_in,
   input wire logic timer_osc_active,
   input wire logic [PORT_W-1:0] pin_level
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);

   a_reset_quiet: assert property (disable iff (1'b0)
      reset |=> pad_drive.oe == 8'h00) else $error("pad driven after reset");
   a_force_drive: assert property (periph_req.force_out[7] |=>
      pad_drive.oe[7]) else $error("forced output not driven");
   a_force_input: assert property (periph_req.force_in[6] &&
      !periph_req.force_out[6] |=> !pad_drive.oe[6])
      else $error("forced input driven");
   a_osc_no_drive: assert property (timer_osc_active &&
      periph_req.force_out[1:0] == 2'b00 |=> pad_drive.oe[1:0] == 2'b00)
      else $error("osc pins driven");
   a_osc_no_read: assert property (timer_osc_active |=>
      pin_level[1:0] == 2'b00) else $error("osc pins read");
   a_usb_pins_idle: assert property (!usb_req.drive_en &&
      periph_req.force_out[5:4] == 2'b00 |=> pad_drive.oe[5:4] == 2'b00)
      else $error("usb pins driven");
   a_rx_exclusive: assert property (!((usb_minus_in || usb_plus_in) &&
      (xcvr_minus_rx || xcvr_plus_rx)))
      else $error("both receive paths active");
   a_ext_clock: assert property (timer_ext_clock_in && !$past(reset) |->
      $past(pad_in[0])) else $error("timer clock without pin level");
   a_pin_sample: assert property (!$past(reset) |->
      pin_level[7] == $past(pad_in[7]) && pin_level[3] == $past(pad_in[3]))
      else $error("pin level not sampled");
endmodule

bind gpio_port gpio_port_checker #(.PORT_W(PORT_W)) u_gpio_port_checker (
   .sys_clk(sys_clk), .reset(reset), .periph_req(periph_req),
   .usb_req(usb_req), .pad_in(pad_in), .pad_drive(pad_drive),
   .usb_minus_in(usb_minus_in), .usb_plus_in(usb_plus_in),
   .xcvr_minus_rx(xcvr_minus_rx), .xcvr_plus_rx(xcvr_plus_rx),
   .timer_ext_clock_in(timer_ext_clock_in),
   .timer_osc_active(timer_osc_active), .pin_level(pin_level));

`default_nettype wire

// [gpio_port_pkg.sv]
`default_nettype none

package gpio_port_pkg;

   localparam int PORT_W = 8;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // Register byte offsets on the APB
   localparam logic [11:0] OFS_PIN_LEVEL = 12'h000;
   localparam logic [11:0] OFS_DIRECTION = 12'h004;
   localparam logic [11:0] OFS_OUT_LATCH = 12'h008;
   localparam logic [11:0] OFS_USB_CTRL = 12'h00C;
   localparam logic [11:0] OFS_USB_CFG = 12'h010;
   localparam logic [11:0] OFS_ANALOG_CFG = 12'h014;
   localparam logic [11:0] OFS_PERIPH_CTRL = 12'h018;

   // Field positions
   localparam int USB_EN_BIT = 3;
   localparam int XCVR_DIS_BIT = 3;
   localparam int PIN2_ANALOG_SEL_BIT = 3;
   localparam int TMR_OSC_EN_BIT = 0;
   localparam int PULSE_EN_BIT = 1;

   // Pin positions
   localparam int PIN_OSC_OUT = 0;
   localparam int PIN_OSC_IN = 1;
   localparam int PIN_ANALOG = 2;
   localparam int PIN_USB_MINUS = 4;
   localparam int PIN_USB_PLUS = 5;

   // Implemented bits of direction and latch; pins 4 and 5 have none
   localparam logic [7:0] DIR_IMPL_MASK = 8'hCF;
   localparam logic [7:0] LAT_IMPL_MASK = 8'hCF;

   // Reset values
   localparam logic [7:0] DIR_RST = 8'hCF;
   localparam logic [7:0] LAT_RST = 8'h00;
   localparam logic [7:0] USB_CTRL_RST = 8'h00;
   localparam logic [7:0] USB_CFG_RST = 8'h00;
   localparam logic [7:0] ANALOG_CFG_RST = 8'h00;
   localparam logic [7:0] PERIPH_CTRL_RST = 8'h00;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } apb_rsp_t;

   // Requests from multiplexed peripherals, one bit per pin
   typedef struct packed {
      logic [7:0] force_out;
      logic [7:0] force_in;
      logic [7:0] sel;
      logic [7:0] data;
   } periph_req_t;

   // Requests from the USB engine
   typedef struct packed {
      logic drive_en;
      logic minus_out;
      logic plus_out;
      logic xcvr_oe_n;
   } usb_req_t;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } pad_drive_t;

endpackage

`default_nettype wire

// [test_port_c_gpio_with_usb_pins.sv]
`timescale 1ns/1ps
`default_nettype none

module test_port_c_gpio_with_usb_pins;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   gpio_port_pkg::apb_req_t req = '0;
   gpio_port_pkg::apb_rsp_t rsp;
   gpio_port_pkg::periph_req_t per = '0;
   gpio_port_pkg::usb_req_t usb = '0;
   gpio_port_pkg::pad_drive_t pd;
   logic [7:0] pad_in, pin_level, r1, r2, r3, pl;
   logic [7:0] ext_val = 8'h00;
   logic umi, upi, xmi, xpi, tck, tosc;
   logic chk = 1'b0;
   logic [63:0] q[$];
   int failures = 0;
   int comparisons = 0;
   int seed = 32'h8FA5;

   always #50 sys_clk = ~sys_clk;

   gpio_port u_gpio_port (.sys_clk(sys_clk), .reset(reset), .apb_req(req),
      .apb_rsp(rsp), .periph_req(per), .usb_req(usb), .pad_in(pad_in),
      .pad_drive(pd), .usb_minus_in(umi), .usb_plus_in(upi),
      .xcvr_minus_rx(xmi), .xcvr_plus_rx(xpi), .timer_ext_clock_in(tck),
      .timer_osc_active(tosc), .pin_level(pin_level));
   gpio_board_model u_gpio_board_model (.pad_drive(pd), .ext_val(ext_val),
      .pad_in(pad_in));

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // One idle cycle after each transfer keeps psel from being set twice
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge sys_clk);
      req.penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 16);
      req <= '0;
      @(posedge sys_clk);
      if (n >= 16) begin
         failures++;
         end_sim();
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      xfer(1'b1, a, {24'h0, d});
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      // Offsets past the last register answer with an error
      q.push_back({32'hFFFFFFFF, a > gpio_port_pkg::OFS_PERIPH_CTRL,
         23'h0, e});
      xfer(1'b0, a, 32'h0);
   endtask

   // Register to pad takes two edges, pad to pin level one more
   task automatic look(input logic [31:0] m, input logic [31:0] e);
      repeat (3) @(posedge sys_clk);
      q.push_back({m, e});
      chk <= 1'b1;
      @(posedge sys_clk);
      chk <= 1'b0;
      @(posedge sys_clk);
   endtask

   always @(posedge sys_clk) begin
      logic [31:0] got;
      logic [63:0] e;
      logic rdv;
      rdv = req.psel && req.penable && rsp.pready && !req.pwrite;
      got = rdv ? {rsp.pslverr, rsp.prdata[30:0]} :
         {2'b00, pin_level, umi, upi, xmi, xpi, tck, tosc, pd};
      if (rdv || chk) begin
         e = q.pop_front();
         comparisons++;
         if ((got & e[63:32]) !== (e[31:0] & e[63:32])) begin
            failures++;
            $display("mismatch at %0t got %h expected %h", $time,
               got & e[63:32], e[31:0]);
         end
      end
   end

   initial begin
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      ext_val <= 8'hFF;
      @(posedge sys_clk);
      rd(12'h004, 8'hCF);
      rd(12'h008, 8'h00);
      rd(12'h010, 8'h00);
      rd(12'h01C, 8'h00);
      look(32'h3FC0FFFF, {2'b00, 8'hCB, 22'h0});
      $display("reset test done");
      for (int i = 0; i < 4; i++) begin
         r1 = 8'($random(seed));
         r2 = 8'($random(seed));
         r3 = 8'($random(seed));
         ext_val <= r3;
         wr(12'h004, r1);
         wr(12'h000, r2);
         pl = ((r2 & ~r1) | (r3 & r1)) & 8'hCB;
         rd(12'h004, r1 & 8'hCF);
         rd(12'h008, r2 & 8'hCF);
         look(32'h3FC0FFFF,
            {2'b00, pl, 6'h0, r2 & 8'hCF, ~r1 & 8'hCF});
         rd(12'h000, pl);
      end
      $display("direction test done");
      wr(12'h004, 8'h00);
      wr(12'h008, 8'h00);
      wr(12'h018, 8'h02);
      // Pin 2 is not selected here, so only the pulse enable can drive it
      per <= '{force_out: 8'h80, force_in: 8'h40, sel: 8'h81, data: 8'h85};
      look(32'h0000FFFF, 32'h0000858F);
      rd(12'h004, 8'h00);
      per <= '0;
      $display("override test done");
      wr(12'h018, 8'h01);
      wr(12'h008, 8'hFF);
      look(32'h00C10003, 32'h00010000);
      wr(12'h018, 8'h00);
      wr(12'h004, 8'h01);
      ext_val <= 8'h01;
      look(32'h00020000, 32'h00020000);
      $display("timer test done");
      wr(12'h004, 8'h00);
      ext_val <= 8'h30;
      usb <= '{drive_en: 1'b1, minus_out: 1'b1, plus_out: 1'b0,
         xcvr_oe_n: 1'b0};
      wr(12'h00C, 8'h08);
      wr(12'h010, 8'h00);
      look(32'h0C3C3030, 32'h00201030);
      wr(12'h010, 8'h08);
      look(32'h0C3C0232, 32'h000C0002);
      wr(12'h00C, 8'h00);
      look(32'h0C3C0030, 32'h0C000000);
      wr(12'h014, 8'h08);
      look(32'h01000000, 32'h01000000);
      $display("usb test done");
      end_sim();
   end
endmodule

`default_nettype wire
